// ==== sgs_selector.sv ====
// Purpose: picks the active parameter set from request inputs and operator commands
// Assumes: settings and operator commands are on clk_in; group request inputs are pins
// Notes:   active group is one-hot with param_set_one in bit 0; events via event_stamper
`timescale 1ns/100ps
`include "sgs_consts.svh"
module param_set_selector
    import group_sel_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire logic [7:0]              group_req_in,
    input  wire logic                    force_change_enable_in,
    input  wire logic [2:0]              used_groups_in,
    input  wire logic [3:0]              remote_change_in,
    input  wire logic                    local_req_in,
    input  wire logic [3:0]              local_group_in,
    input  wire logic [3:0]              force_group_in,
    input  wire logic [`EV_WIDTH-1:0]    event_on_sel_in,
    input  wire logic [`EV_WIDTH-1:0]    event_off_sel_in,
    output logic      [7:0]              active_group_out,
    output logic      [3:0]              active_code_out,
    output logic                         force_mode_out,
    output logic      [7:0]              group_default_load_out,
    output logic      [`EV_WIDTH-1:0]    event_on_out,
    output logic      [`EV_WIDTH-1:0]    event_off_out,
    output logic      [`STAMP_WIDTH-1:0] event_stamp_out,
    output logic                         event_valid_out
);

    // synchronised request pins and their history
    logic [7:0]           req_meta;
    logic [7:0]           req_sync;
    logic [7:0]           req_prev;
    logic [1:0]           hold_cnt [0:7];
    group_mask_type       held;
    group_mask_type       rise;

    // operator command history for change detection
    group_code_type       remote_prev;
    group_code_type       force_prev;
    logic                 local_prev;
    logic [2:0]           used_prev;

    // state
    mode_type             mode;
    mode_type             next_mode;
    group_mask_type       active;
    group_mask_type       next_active;
    logic                 fail_cfg;
    logic                 fail_force;
    logic                 fail_prio;
    logic                 next_fail_cfg;
    logic                 next_fail_force;
    logic                 next_fail_prio;

    // decode
    group_mask_type       in_service;
    group_mask_type       allowed;
    group_mask_type       auto_pick;
    group_mask_type       man_mask;
    logic                 man_req;
    logic                 man_is_remote;
    logic                 force_new;
    logic                 remote_new;
    logic                 local_new;
    logic [`EV_WIDTH-1:0] cond;

    // two flops on the pins before anything looks at them
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            req_meta <= 8'h00;
            req_sync <= 8'h00;
            req_prev <= 8'h00;
        end else begin
            req_meta <= group_req_in;
            req_sync <= req_meta;
            req_prev <= req_sync;
        end
    end

    // per-group level counters: a short pulse selects, a long level also holds
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < `SG_GROUPS; i++) begin
                hold_cnt[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < `SG_GROUPS; i++) begin
                if (!req_sync[i]) begin
                    hold_cnt[i] <= 2'h0;
                end else if (hold_cnt[i] != `SG_STATIC_CYCLES) begin
                    hold_cnt[i] <= hold_cnt[i] + 2'h1;
                end
            end
        end
    end

    // pulse starts and static holds of each request input; a hold ends in the
    // same cycle as its synced level, so a released group blocks nothing
    always_comb begin
        rise = req_sync & ~req_prev;
        held = 8'h00;
        for (int i = 0; i < `SG_GROUPS; i++) begin
            held[i] = req_sync[i] && (hold_cnt[i] == `SG_STATIC_CYCLES);
        end
    end

    // only groups at or above the highest static hold may be picked automatically or by remote command;
    // a hold on the last group therefore leaves every group allowed
    always_comb begin
        in_service = in_service_mask(used_groups_in);
        allowed    = at_or_above(pick_highest(held));
        auto_pick  = pick_highest((rise | held) & allowed);
    end

    // operator command starts: a new nonzero value or a rising panel strobe
    always_comb begin
        force_new  = (force_group_in != force_prev) && (force_group_in != `SG_CODE_NONE);
        remote_new = (remote_change_in != remote_prev)
                     && (remote_change_in != `SG_CODE_NONE);
        local_new  = local_req_in && !local_prev;
    end

    // one operator command per cycle: forced selection, then remote, then panel
    always_comb begin
        man_req       = force_new | remote_new | local_new;
        man_is_remote = 1'b0;
        man_mask      = 8'h00;
        if (force_new) begin
            man_mask = code_to_mask(force_group_in);
        end else if (remote_new) begin
            man_mask      = code_to_mask(remote_change_in);
            man_is_remote = 1'b1;
        end else if (local_new) begin
            man_mask = code_to_mask(local_group_in);
        end
    end

    // command history registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            remote_prev <= `SG_CODE_NONE;
            force_prev  <= `SG_CODE_NONE;
            local_prev  <= 1'b0;
            used_prev   <= 3'h0;
        end else begin
            remote_prev <= remote_change_in;
            force_prev  <= force_group_in;
            local_prev  <= local_req_in;
            used_prev   <= used_groups_in;
        end
    end

    // forcing lasts exactly as long as the enable setting
    always_comb begin
        next_mode = mode;
        unique case (mode)
            MODE_AUTO: begin
                if (force_change_enable_in) begin
                    next_mode = MODE_FORCE;
                end
            end
            MODE_FORCE: begin
                if (!force_change_enable_in) begin
                    next_mode = MODE_AUTO;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode <= MODE_AUTO;
        end else begin
            mode <= next_mode;
        end
    end

    // selection and refusal decisions for the current cycle
    always_comb begin
        next_active     = active;
        next_fail_cfg   = 1'b0;
        next_fail_force = 1'b0;
        next_fail_prio  = 1'b0;
        unique case (mode)
            MODE_AUTO: begin
                // operator commands are refused while forcing is off
                if (man_req) begin
                    next_fail_force = 1'b1;
                end
                // a fresh pulse below a static hold is refused and reported
                if ((rise & ~allowed) != 8'h00) begin
                    next_fail_prio = 1'b1;
                end
                if (used_groups_in == 3'h0) begin
                    next_active = `SG_ACTIVE_RESET;
                end else if ((auto_pick & ~in_service) != 8'h00) begin
                    next_fail_cfg = 1'b1;
                end else if (auto_pick != 8'h00) begin
                    next_active = auto_pick;
                end
            end
            MODE_FORCE: begin
                // while forcing is on, request pins matter only through static holds that refuse remote commands
                if (man_req) begin
                    if ((man_mask & in_service) == 8'h00) begin
                        next_fail_cfg = 1'b1;
                    end else if (man_is_remote && ((man_mask & ~allowed) != 8'h00)) begin
                        next_fail_prio = 1'b1;
                    end else begin
                        next_active = man_mask;
                    end
                end
            end
        endcase
        // a group taken out of service cannot stay active
        if ((next_active & in_service) == 8'h00) begin
            next_active = `SG_ACTIVE_RESET;
        end
    end

    // active group register; changes the cycle after a request is taken
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            active <= `SG_ACTIVE_RESET;
        end else begin
            active <= next_active;
        end
    end

    // refusal flags are levels: a lasting refused hold gives one on, one off
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fail_cfg   <= 1'b0;
            fail_force <= 1'b0;
            fail_prio  <= 1'b0;
        end else begin
            fail_cfg   <= next_fail_cfg;
            fail_force <= next_fail_force;
            fail_prio  <= next_fail_prio;
        end
    end

    // groups entering service load defaults; pulse lasts one cycle
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            group_default_load_out <= 8'h00;
        end else begin
            group_default_load_out <= in_service & ~in_service_mask(used_prev);
        end
    end

    // registered views of the selection
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            active_code_out <= `SG_CODE_ONE;
            force_mode_out  <= `SG_FORCE_RESET;
        end else begin
            active_code_out <= mask_to_code(next_active);
            force_mode_out  <= (next_mode == MODE_FORCE);
        end
    end

    assign active_group_out = active;

    // monitored conditions; spare bits never change and never report
    always_comb begin
        cond                                = '0;
        cond[`EV_ENABLED_LSB +: 8]          = in_service;
        cond[`EV_REQUEST_LSB +: 8]          = req_sync;
        cond[`EV_ACTIVE_LSB +: 8]           = active;
        cond[`EV_REMOTE_BIT]                = (remote_change_in != `SG_CODE_NONE);
        cond[`EV_LOCAL_BIT]                 = local_req_in;
        cond[`EV_FORCE_BIT]                 = (mode == MODE_FORCE);
        cond[`EV_FAIL_CFG_BIT]              = fail_cfg;
        cond[`EV_FAIL_FORCE_BIT]            = fail_force;
        cond[`EV_FAIL_PRIO_BIT]             = fail_prio;
    end

    // stamping of the condition changes picked by the on/off selections
    event_stamper u_event_stamp (
        .clk_in          (clk_in),
        .srst_in         (srst_in),
        .cond_in         (cond),
        .on_sel_in       (event_on_sel_in),
        .off_sel_in      (event_off_sel_in),
        .event_on_out    (event_on_out),
        .event_off_out   (event_off_out),
        .event_stamp_out (event_stamp_out),
        .event_valid_out (event_valid_out)
    );

endmodule

// ==== sgs_consts.svh ====
// Purpose: constants of the parameter-set selector and its event stamping
// Assumes: included by the design files by bare name
// Notes:   definitions only; widths match the ports they meet
`ifndef GROUP_SEL_CONSTS_SVH
`define GROUP_SEL_CONSTS_SVH

// number of parameter sets and the code that means "no group"
`define SG_GROUPS         8
`define SG_CODE_NONE      4'h0
`define SG_CODE_ONE       4'h1

// reset values: param_set_one active, forcing disabled
`define SG_ACTIVE_RESET   8'h01
`define SG_FORCE_RESET    1'b0

// a request input still high after this many cycles in a row counts as a static level
`define SG_STATIC_CYCLES  2'h2

// layout of the monitored-condition vector fed to the event stamper
`define EV_WIDTH          32
`define EV_ENABLED_LSB    0
`define EV_REQUEST_LSB    8
`define EV_ACTIVE_LSB     16
`define EV_REMOTE_BIT     24
`define EV_LOCAL_BIT      25
`define EV_FORCE_BIT      26
`define EV_FAIL_CFG_BIT   27
`define EV_FAIL_FORCE_BIT 28
`define EV_FAIL_PRIO_BIT  29
`define EV_SPARE_LSB      30

// time stamp counter width and step per clock
`define STAMP_WIDTH       32
`define STAMP_STEP        32'h0000_0001

`endif

// ==== sgs_pkg.sv ====
// Purpose: types and shared decode functions of the parameter-set selector
// Assumes: group one is the highest priority and sits in bit 0 of a mask
// Notes:   group codes are 0 for none and 1..8 for the groups
package group_sel_pkg;

    typedef logic [3:0] group_code_type;
    typedef logic [7:0] group_mask_type;

    // operating mode, one-hot
    typedef enum logic [1:0] {
        MODE_AUTO  = 2'b01,
        MODE_FORCE = 2'b10
    } mode_type;

    // group code to one-hot mask; none or out-of-range gives an empty mask
    function automatic group_mask_type code_to_mask(input group_code_type code);
        group_mask_type m;
        m = 8'h00;
        if (code >= 4'h1 && code <= 4'h8) begin
            m = 8'h01 << (code - 4'h1);
        end
        return m;
    endfunction

    // keep only the highest-priority (lowest-numbered) group of a mask
    function automatic group_mask_type pick_highest(input group_mask_type m);
        return m & (~m + 8'h01);
    endfunction

    // groups at or above a one-hot group; an empty input allows every group
    function automatic group_mask_type at_or_above(input group_mask_type top);
        return (top << 1) - 8'h01;
    endfunction

    // groups in service: count-minus-one setting to a mask of groups one..n+1
    function automatic group_mask_type in_service_mask(input logic [2:0] n);
        return (8'h02 << n) - 8'h01;
    endfunction

    // one-hot mask back to a group code
    function automatic group_code_type mask_to_code(input group_mask_type m);
        group_code_type c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                c = 4'(i + 1);
            end
        end
        return c;
    endfunction

endpackage

// ==== sgs_event_stamp.sv ====
// Purpose: turns changes of monitored conditions into stamped on/off events
// Assumes: conditions come from logic on the same clock
// Notes:   all changes seen in one cycle share one stamp and one valid pulse
`timescale 1ns/100ps
`include "sgs_consts.svh"
module event_stamper (
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire logic [`EV_WIDTH-1:0]    cond_in,
    input  wire logic [`EV_WIDTH-1:0]    on_sel_in,
    input  wire logic [`EV_WIDTH-1:0]    off_sel_in,
    output logic      [`EV_WIDTH-1:0]    event_on_out,
    output logic      [`EV_WIDTH-1:0]    event_off_out,
    output logic      [`STAMP_WIDTH-1:0] event_stamp_out,
    output logic                         event_valid_out
);

    logic [`EV_WIDTH-1:0]    cond_prev;
    logic [`STAMP_WIDTH-1:0] stamp;
    logic [`EV_WIDTH-1:0]    next_on;
    logic [`EV_WIDTH-1:0]    next_off;

    // rising edges are on events, falling edges off events, each filtered
    always_comb begin
        next_on  = cond_in & ~cond_prev & on_sel_in;
        next_off = ~cond_in & cond_prev & off_sel_in;
    end

    // free-running time base; wraps silently, software extends it if needed
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stamp <= '0;
        end else begin
            stamp <= stamp + `STAMP_STEP;
        end
    end

    // previous conditions; zero at reset so the initial state is reported
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cond_prev <= '0;
        end else begin
            cond_prev <= cond_in;
        end
    end

    // stored events carry the stamp of the cycle the change was seen
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            event_on_out    <= '0;
            event_off_out   <= '0;
            event_stamp_out <= '0;
            event_valid_out <= 1'b0;
        end else begin
            event_on_out    <= next_on;
            event_off_out   <= next_off;
            event_stamp_out <= stamp;
            event_valid_out <= |{next_on, next_off};
        end
    end

endmodule

// ==== sgs_selector_assertions.sv ====
// Purpose: port-level checks of the parameter-set selector
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every param_set_selector instance
`timescale 1ns/100ps
`include "sgs_consts.svh"
module param_set_checker (
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic [7:0]  group_req_in,
    input wire logic        force_change_enable_in,
    input wire logic [2:0]  used_groups_in,
    input wire logic [3:0]  remote_change_in,
    input wire logic        local_req_in,
    input wire logic [3:0]  local_group_in,
    input wire logic [3:0]  force_group_in,
    input wire logic [31:0] event_on_sel_in,
    input wire logic [31:0] event_off_sel_in,
    input wire logic [7:0]  active_group_out,
    input wire logic [3:0]  active_code_out,
    input wire logic        force_mode_out,
    input wire logic [7:0]  group_default_load_out,
    input wire logic [31:0] event_on_out,
    input wire logic [31:0] event_off_out,
    input wire logic [31:0] event_stamp_out,
    input wire logic        event_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic [3:0] hold_one;
    // cycles group one pin held with forcing off; margin covers sync and static delay
    always_ff @(posedge clk_in) begin
        if (srst_in || !group_req_in[0] || force_change_enable_in || force_mode_out) begin
            hold_one <= 4'h0;
        end else if (hold_one != 4'hF) begin
            hold_one <= hold_one + 4'h1;
        end
    end
    // forcing with no operator command and no service change
    sequence quiet_s;
        force_mode_out && $stable(force_group_in) && $stable(remote_change_in)
            && !$rose(local_req_in) && $stable(used_groups_in);
    endsequence
    sequence refused_s;
        !force_change_enable_in && !force_mode_out && $changed(force_group_in)
            && force_group_in != 4'h0 && event_on_sel_in[`EV_FAIL_FORCE_BIT];
    endsequence
    reset_values_a: assert property (disable iff (1'b0) srst_in |=>
        active_group_out == 8'h01 && active_code_out == 4'h1 && !force_mode_out)
        else $error("wrong state after reset");
    active_onehot_a: assert property ($onehot(active_group_out))
        else $error("active group not one-hot");
    code_match_a: assert property (
        active_group_out == (8'h01 << (active_code_out - 4'h1)))
        else $error("active code and mask disagree");
    force_mode_a: assert property (force_mode_out == $past(force_change_enable_in))
        else $error("force mode does not follow enable");
    forced_hold_a: assert property (quiet_s [*3] |=> $stable(active_group_out))
        else $error("active group moved while forcing");
    hold_one_a: assert property (hold_one >= 4'h8 |-> active_group_out == 8'h01)
        else $error("held group one lost control");
    event_valid_a: assert property (
        event_valid_out == ((event_on_out | event_off_out) != 32'h0))
        else $error("event valid disagrees with event bits");
    event_select_a: assert property ($stable(event_on_sel_in) && $stable(event_off_sel_in)
        |-> ((event_on_out & ~event_on_sel_in) | (event_off_out & ~event_off_sel_in)) == 32'h0)
        else $error("deselected event reported");
    stamp_step_a: assert property (event_valid_out ##1 event_valid_out |->
        event_stamp_out == $past(event_stamp_out) + `STAMP_STEP)
        else $error("stamp did not advance by one");
    force_fail_a: assert property (refused_s |-> ##[1:3] event_on_out[`EV_FAIL_FORCE_BIT])
        else $error("refused forced change raised no event");
endmodule
bind param_set_selector param_set_checker chk (.clk_in, .srst_in, .group_req_in,
    .force_change_enable_in, .used_groups_in, .remote_change_in, .local_req_in,
    .local_group_in, .force_group_in, .event_on_sel_in, .event_off_sel_in,
    .active_group_out, .active_code_out, .force_mode_out, .group_default_load_out,
    .event_on_out, .event_off_out, .event_stamp_out, .event_valid_out);

// ==== sgs_req_source.sv ====
// Purpose: request sources in front of the selector pins
// Assumes: sources switch on clk_in like the internal logic they stand for
// Notes:   a pulse lasts one cycle; a level lasts as long as it is held
`timescale 1ns/100ps
module req_source (
    input  wire logic       clk_in,
    input  wire logic [7:0] level_in,
    input  wire logic [7:0] pulse_in,
    output logic      [7:0] group_req_out
);
    initial group_req_out = 8'h00;
    // each pin carries a held level, a one-cycle pulse, or both
    always @(posedge clk_in) begin
        group_req_out <= level_in | pulse_in;
    end
endmodule

// ==== tb_top.sv ====
// Purpose: self-checking bench of the parameter-set selector
// Assumes: 100 MHz clock, events on/off selection held constant
// Notes:   off events of the panel strobe are masked to test selection
`timescale 1ns/100ps
module tb_top;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  lvl, pls, req, active, dload, acc_load;
    logic [3:0]  code, remote, lgrp, fgrp, g;
    logic [2:0]  used;
    logic        force_en, local_req, fmode, valid;
    logic [31:0] on_sel, off_sel, ev_on, ev_off, stamp, acc_on, acc_off, seed;
    int          fail_count, samples_checked;

    always #5 clk_in = ~clk_in;
    // gather event pulses so checks need not hit the exact cycle
    always @(posedge clk_in) begin
        acc_on <= acc_on | ev_on;
        acc_off <= acc_off | ev_off;
        acc_load <= acc_load | dload;
    end

    req_source src (.clk_in(clk_in), .level_in(lvl), .pulse_in(pls), .group_req_out(req));
    param_set_selector uut (.clk_in(clk_in), .srst_in(srst_in), .group_req_in(req),
        .force_change_enable_in(force_en), .used_groups_in(used), .remote_change_in(remote),
        .local_req_in(local_req), .local_group_in(lgrp), .force_group_in(fgrp),
        .event_on_sel_in(on_sel), .event_off_sel_in(off_sel), .active_group_out(active),
        .active_code_out(code), .force_mode_out(fmode), .group_default_load_out(dload),
        .event_on_out(ev_on), .event_off_out(ev_off), .event_stamp_out(stamp),
        .event_valid_out(valid));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // lowest-numbered requested group wins
    function automatic logic [7:0] win(input logic [7:0] m);
        for (int i = 0; i < 8; i++) if (m[i]) return 8'h01 << i;
        return 8'h00;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic clr;
        @(negedge clk_in);
        acc_on = 32'h0;
        acc_off = 32'h0;
        acc_load = 8'h00;
    endtask
    // one-cycle pulse, then wait past sync and decision
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_in);
        pls <= m;
        @(posedge clk_in);
        pls <= 8'h00;
        cyc(6);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        finish_test;
    end

    initial begin
        fail_count = 0;
        samples_checked = 0;
        seed = 32'h81796C52;
        {lvl, pls, force_en, used, remote, local_req, fgrp} = '0;
        lgrp = 4'h1;
        on_sel = 32'hFFFF_FFFF;
        off_sel = 32'hFDFF_FFFF;
        {acc_on, acc_off, acc_load} = '0;
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        cyc(2);
        check(active, 8'h01, "reset group");
        check(fmode, 1'b0, "reset force");
        clr;
        @(posedge clk_in) used <= 3'h7;
        cyc(4);
        check(acc_load, 8'hFE, "default load");
        $display("test service done");
        pulse(8'h04);
        check(code, 4'h3, "pulse code");
        cyc(10);
        check(active, 8'h04, "pulse stays");
        // corner case first, then random simultaneous requests
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            g = 4'h0;
            pulse(i == 0 ? 8'hA0 : (seed[7:0] | 8'h80));
            check(active, win(i == 0 ? 8'hA0 : (seed[7:0] | 8'h80)), "priority");
        end
        $display("test priority done");
        @(posedge clk_in) lvl <= 8'h10;
        cyc(6);
        check(active, 8'h10, "static five");
        clr;
        pulse(8'h40);
        check(active, 8'h10, "five blocks seven");
        check(acc_on[29], 1'b1, "lower priority event");
        @(posedge clk_in) lvl <= 8'h12;
        cyc(6);
        check(active, 8'h02, "higher static wins");
        @(posedge clk_in) lvl <= 8'h80;
        cyc(6);
        @(posedge clk_in) lvl <= 8'hA0;
        cyc(6);
        check(active, 8'h20, "eight blocks nothing");
        @(posedge clk_in) lvl <= 8'h01;
        cyc(6);
        pulse(8'h02);
        check(active, 8'h01, "one blocks all");
        @(posedge clk_in) lvl <= 8'h00;
        $display("test static done");
        clr;
        @(posedge clk_in) fgrp <= 4'h4;
        cyc(4);
        check(active, 8'h01, "force without enable");
        check(acc_on[28], 1'b1, "force fail event");
        @(posedge clk_in) force_en <= 1'b1;
        cyc(2);
        check(fmode, 1'b1, "force mode");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            g = ((fgrp + {2'b00, seed[1:0]}) % 4'h8) + 4'h1;
            @(posedge clk_in) fgrp <= g;
            cyc(2);
            check(active, 8'h01 << (g - 4'h1), "forced group");
        end
        pulse(8'h01 << (g % 4'h8));
        check(active, 8'h01 << (g - 4'h1), "pins ignored");
        @(posedge clk_in) remote <= 4'h7;
        cyc(2);
        check(active, 8'h40, "remote change");
        @(posedge clk_in) lvl <= 8'h02;
        cyc(6);
        clr;
        @(posedge clk_in) remote <= 4'h5;
        cyc(3);
        check(active, 8'h40, "remote under hold");
        check(acc_on[29], 1'b1, "remote refused event");
        @(posedge clk_in) lvl <= 8'h00;
        $display("test force done");
        clr;
        @(posedge clk_in) lgrp <= 4'h6;
        for (int i = 0; i < 4; i++) @(posedge clk_in) local_req <= ~local_req;
        cyc(3);
        check(active, 8'h20, "panel change");
        check(acc_on[25], 1'b1, "panel on event");
        check(acc_off[25], 1'b0, "panel off masked");
        @(posedge clk_in) used <= 3'h1;
        @(posedge clk_in) remote <= 4'h2;
        cyc(2);
        clr;
        @(posedge clk_in) remote <= 4'h8;
        cyc(3);
        check(active, 8'h02, "group out of service");
        check(acc_on[27], 1'b1, "not configured event");
        clr;
        @(posedge clk_in) force_en <= 1'b0;
        cyc(3);
        check(fmode, 1'b0, "force cleared");
        check(acc_off[26], 1'b1, "force off event");
        pulse(8'h01);
        check(active, 8'h01, "automatic again");
        $display("test operator done");
        finish_test;
    end
endmodule
